// [design/incremental_adc_regs.vh]
// Constants shared by the incremental converter sequencer and its clock divider.
// Assumes inclusion by bare name from files under design/.
`ifndef INCREMENTAL_ADC_REGS_VH
`define INCREMENTAL_ADC_REGS_VH

// Oscillator and slowest over-sampling rate, and the divide ratio between them.
`define OSC_FREQ_HZ        4000000
`define FS_SLOWEST_HZ      62500
`define OS_DIV_MAX         (`OSC_FREQ_HZ / `FS_SLOWEST_HZ)
`define OS_DIV_W           6

// Field widths of the configuration inputs.
`define CLK_SEL_W          2
`define OSR_CODE_W         3
`define NELC_CODE_W        2
`define BG_MODE_W          2

// Over-sampling ratio is two to the power of this base plus the code.
`define OSR_EXP_BASE       6'h03

// Bandgap reference state encodings.
`define BG_FORCE_HIGH      2'h0
`define BG_FORCE_LOW       2'h1
`define BG_TOGGLE_FULL     2'h2
`define BG_TOGGLE_HALF     2'h3

// Result register layout, reset value and saturation limits.
`define RESULT_W           16
`define RESULT_RESET       16'h0000
`define RESULT_MAX         16'h7FFF
`define RESULT_MIN         16'h8000

// Accumulator and counter widths.
`define ACC1_W             12
`define ACC2_W             22
`define SUM_W              26
`define WIDE_W             40
`define PER_CNT_W          11
`define ELEM_CNT_W         3

`endif

// [design/incremental_adc_sequencer.v]
// Sequencer for an incremental over-sampling converter behind a gain chain.
// Assumes the modulator bit and oscillator arrive asynchronously and the
// trigger and configuration inputs come from logic clocked by mclk_in.
`timescale 1ns/1ps
`include "incremental_adc_regs.vh"

// Notes on behaviour
// - Either trigger input starts a new sequence.
// - Sequence is N elementary conversions plus quantization.
// - Each elementary conversion lasts OVERSAMPLE_RATIO plus one periods.
// - Result is mean of elementary results.
// - Offset polarity alternates between elementary conversions.
// - Bandgap forced high, low, or toggling.
// - Over-sampling clock divided from 4 MHz oscillator.
// - Ratio is two to power three-plus-code.
// - Conversion count is two to power code.
// - Resolution twice log2 ratio plus log2 count.
// - Total time is N(OVERSAMPLE_RATIO+1)+1 periods.
// - Result is saturated 16-bit two's complement.
// - Non-significant low bits forced to fixed pattern.
module incremental_adc_sequencer (
   input  wire                     mclk_in,
   input  wire                     reset_in,
   input  wire                     conversion_trigger_in,
   input  wire                     alt_conversion_trigger_in,
   input  wire [`CLK_SEL_W-1:0]    oversample_clock_select_in,
   input  wire [`OSR_CODE_W-1:0]   oversample_ratio_code_in,
   input  wire [`NELC_CODE_W-1:0]  elem_conversion_count_code_in,
   input  wire [`BG_MODE_W-1:0]    bandgap_mode_in,
   input  wire                     osc_4mhz_in,
   input  wire                     modulator_bit_in,
   output reg  [`RESULT_W-1:0]     conversion_result_out,
   output reg                      result_valid_out,
   output reg                      busy_out,
   output reg                      offset_polarity_out,
   output reg                      bandgap_state_out,
   output reg                      modulator_reset_out,
   output reg                      os_sample_out
);

   localparam ST_IDLE  = 2'h0;
   localparam ST_ELEM  = 2'h1;
   localparam ST_FINAL = 2'h2;
   localparam ST_DONE  = 2'h3;

   reg  [1:0]                 state_reg;
   reg  [`OSR_CODE_W-1:0]     osr_code_reg;
   reg  [`NELC_CODE_W-1:0]    nelc_code_reg;
   reg  [`BG_MODE_W-1:0]      bg_mode_reg;
   reg  [`PER_CNT_W-1:0]      per_cnt_reg;
   reg  [`ELEM_CNT_W-1:0]     elem_cnt_reg;
   reg  signed [`ACC1_W-1:0]  acc1_reg;
   reg  signed [`ACC2_W-1:0]  acc2_reg;
   reg  signed [`SUM_W-1:0]   sum_reg;
   reg  [`RESULT_W-1:0]       final_reg;
   reg                        bg_half_reg;
   reg                        mod_meta_reg;
   reg                        mod_sync_reg;
   wire                       os_tick;
   wire                       trigger;
   wire [`PER_CNT_W-1:0]      osr_value;
   wire [`ELEM_CNT_W-1:0]     elem_last;
   reg  signed [`ACC1_W-1:0]  step;
   reg  signed [`ACC1_W-1:0]  acc1_next;
   reg  signed [`WIDE_W-1:0]  wide;
   reg  signed [6:0]          shift;
   reg  [`RESULT_W-1:0]       sat;
   reg  [4:0]                 res_bits;

   // Resolution in bits for the given codes, capped by the result width.
   function [4:0] resolution;
      input [`OSR_CODE_W-1:0]  osr_code;
      input [`NELC_CODE_W-1:0] nelc_code;
      reg   [5:0]              raw;
      begin
         raw = 6'h02 * ({3'h0, osr_code} + `OSR_EXP_BASE) + {4'h0, nelc_code};
         resolution = (raw > `RESULT_W) ? 5'h10 : raw[4:0];
      end
   endfunction

   // Forces the bits below the resolution to a one followed by zeros.
   function [`RESULT_W-1:0] force_lsbs;
      input [`RESULT_W-1:0] value;
      input [4:0]           n_bits;
      reg   [`RESULT_W-1:0] mask;
      reg   [`RESULT_W-1:0] pattern;
      begin
         mask    = (16'hFFFF >> n_bits);
         pattern = (n_bits < 5'h10) ? ((mask >> 1) + 16'h0001) : 16'h0000;
         force_lsbs = (value & ~mask) | pattern;
      end
   endfunction

   os_clock_divider u_divider (
      .mclk_in         (mclk_in),
      .reset_in        (reset_in),
      .osc_in          (osc_4mhz_in),
      .clock_select_in (oversample_clock_select_in),
      .os_tick_out     (os_tick)
   );

   // Either trigger source starts a sequence, also in the middle of one.
   assign trigger   = conversion_trigger_in | alt_conversion_trigger_in;
   assign osr_value = 11'h008 << osr_code_reg;
   assign elem_last = (3'h1 << nelc_code_reg) - 3'h1;

   // Synchronise the modulator decision bit before anything reads it.
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         mod_meta_reg <= 1'b0;
         mod_sync_reg <= 1'b0;
      end else begin
         mod_meta_reg <= modulator_bit_in;
         mod_sync_reg <= mod_meta_reg;
      end
   end

   // Signed modulator step with the chopping sign applied, and the first integrator.
   always @* begin
      step = mod_sync_reg ? 12'sh001 : -12'sh001;
      if (offset_polarity_out)
         step = -step;
      acc1_next = acc1_reg + step;
   end

   // Scale the summed elementary results to the result width and saturate.
   always @* begin
      shift    = 7'sd2 * ($signed({4'h0, osr_code_reg}) + 7'sd3) + $signed({5'h0, nelc_code_reg}) - 7'sd16;
      wide     = {{(`WIDE_W-`SUM_W){sum_reg[`SUM_W-1]}}, sum_reg};
      if (shift >= 7'sd0)
         wide = wide >>> shift;
      else
         wide = wide <<< (-shift);
      if (wide > 40'sd32767)
         sat = `RESULT_MAX;
      else if (wide < -40'sd32768)
         sat = `RESULT_MIN;
      else
         sat = wide[`RESULT_W-1:0];
      res_bits = resolution(osr_code_reg, nelc_code_reg);
   end

   // Main sequence: elementary conversions, quantization step, result update.
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg             <= ST_IDLE;
         osr_code_reg          <= 3'h0;
         nelc_code_reg         <= 2'h0;
         bg_mode_reg           <= `BG_FORCE_HIGH;
         per_cnt_reg           <= 11'h000;
         elem_cnt_reg          <= 3'h0;
         acc1_reg              <= 12'sh000;
         acc2_reg              <= 22'sh00_0000;
         sum_reg               <= 26'sh000_0000;
         final_reg             <= `RESULT_RESET;
         bg_half_reg           <= 1'b0;
         conversion_result_out <= `RESULT_RESET;
         result_valid_out      <= 1'b0;
         busy_out              <= 1'b0;
         offset_polarity_out   <= 1'b0;
         bandgap_state_out     <= 1'b1;
         modulator_reset_out   <= 1'b1;
         os_sample_out         <= 1'b0;
      end else begin
         result_valid_out <= 1'b0;
         os_sample_out    <= 1'b0;
         if (trigger) begin
            // Ratio, count and bandgap settings are captured so a change mid-sequence cannot upset it; the clock select is not.
            state_reg           <= ST_ELEM;
            osr_code_reg        <= oversample_ratio_code_in;
            nelc_code_reg       <= elem_conversion_count_code_in;
            bg_mode_reg         <= bandgap_mode_in;
            per_cnt_reg         <= 11'h000;
            elem_cnt_reg        <= 3'h0;
            acc1_reg            <= 12'sh000;
            acc2_reg            <= 22'sh00_0000;
            sum_reg             <= 26'sh000_0000;
            bg_half_reg         <= 1'b0;
            busy_out            <= 1'b1;
            offset_polarity_out <= 1'b0;
            modulator_reset_out <= 1'b0;
            bandgap_state_out   <= (bandgap_mode_in != `BG_FORCE_LOW);
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  busy_out            <= 1'b0;
                  modulator_reset_out <= 1'b1;
               end
               ST_ELEM: begin
                  if (os_tick) begin
                     os_sample_out <= 1'b1;
                     if (per_cnt_reg < osr_value) begin
                        // Second-order incremental integration over OVERSAMPLE_RATIO periods.
                        acc1_reg    <= acc1_next;
                        acc2_reg    <= acc2_reg + {{(`ACC2_W-`ACC1_W){acc1_next[`ACC1_W-1]}}, acc1_next};
                        per_cnt_reg <= per_cnt_reg + 11'h001;
                        modulator_reset_out <= (per_cnt_reg == osr_value - 11'h001);
                     end else begin
                        // Extra period ends the elementary conversion and dumps it.
                        sum_reg <= sum_reg + {{(`SUM_W-`ACC2_W){acc2_reg[`ACC2_W-1]}}, acc2_reg};
                        acc1_reg            <= 12'sh000;
                        acc2_reg            <= 22'sh00_0000;
                        per_cnt_reg         <= 11'h000;
                        offset_polarity_out <= ~offset_polarity_out;
                        bg_half_reg         <= ~bg_half_reg;
                        modulator_reset_out <= 1'b0;
                        if (bg_mode_reg == `BG_TOGGLE_FULL)
                           bandgap_state_out <= ~bandgap_state_out;
                        else if (bg_mode_reg == `BG_TOGGLE_HALF && bg_half_reg)
                           bandgap_state_out <= ~bandgap_state_out;
                        if (elem_cnt_reg == elem_last) begin
                           state_reg           <= ST_FINAL;
                           modulator_reset_out <= 1'b1;
                        end else begin
                           elem_cnt_reg <= elem_cnt_reg + 3'h1;
                        end
                     end
                  end
               end
               ST_FINAL: begin
                  // One quantization period closes the sequence.
                  if (os_tick) begin
                     os_sample_out <= 1'b1;
                     final_reg     <= force_lsbs(sat, res_bits);
                     state_reg     <= ST_DONE;
                  end
               end
               ST_DONE: begin
                  // Both bytes change in the same edge, then back to idle.
                  conversion_result_out <= final_reg;
                  result_valid_out      <= 1'b1;
                  busy_out              <= 1'b0;
                  state_reg             <= ST_IDLE;
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// [design/os_clock_divider.v]
// Over-sampling tick generator derived from the 4 MHz oscillator pin.
// Assumes the oscillator pin is asynchronous to mclk_in and much slower than it.
`timescale 1ns/1ps
`include "incremental_adc_regs.vh"

module os_clock_divider (
   input  wire                    mclk_in,
   input  wire                    reset_in,
   input  wire                    osc_in,
   input  wire [`CLK_SEL_W-1:0]   clock_select_in,
   output reg                     os_tick_out
);

   reg                  osc_meta_reg;
   reg                  osc_sync_reg;
   reg                  osc_prev_reg;
   reg [`OS_DIV_W-1:0]  div_cnt_reg;
   wire [`OS_DIV_W-1:0] div_last;
   wire                 osc_rise;

   // Last count of the slowest division, kept wide so the narrowing below is explicit.
   localparam [31:0]    DIV_FULL_LAST = `OS_DIV_MAX - 1;

   // Each select step halves the divide ratio: 64, 32, 16 or 8 oscillator periods.
   assign div_last = DIV_FULL_LAST[`OS_DIV_W-1:0] >> clock_select_in;
   assign osc_rise = osc_sync_reg & ~osc_prev_reg;

   // Two-stage synchroniser, then an edge detector fed by the second stage only.
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
      end else begin
         osc_meta_reg <= osc_in;
         osc_sync_reg <= osc_meta_reg;
         osc_prev_reg <= osc_sync_reg;
      end
   end

   // Count oscillator edges and emit one mclk-wide tick per over-sampling period.
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         div_cnt_reg <= {`OS_DIV_W{1'b0}};
         os_tick_out <= 1'b0;
      end else begin
         os_tick_out <= 1'b0;
         if (osc_rise) begin
            if (div_cnt_reg >= div_last) begin
               div_cnt_reg <= {`OS_DIV_W{1'b0}};
               os_tick_out <= 1'b1;
            end else begin
               div_cnt_reg <= div_cnt_reg + 1'b1;
            end
         end
      end
   end

endmodule

// [dv/adc_modulator_model.sv]
// Behavioural oscillator and modulator beyond the sequencer's analog side.
// Assumes a 1 ns time unit; the oscillator runs free as the chip's time base.
`timescale 1ns/1ps
module adc_modulator_model (
   input  wire       sample_in,
   input  wire       polarity_in,
   input  wire       mod_reset_in,
   input  wire [1:0] mode_in,
   output reg        osc_out,
   output wire       bit_out
);
   reg alt_reg;
   // Free running 4 MHz oscillator, 125 ns per half period.
   initial begin
      osc_out = 1'b0;
      alt_reg = 1'b0;
      forever #125 osc_out = ~osc_out;
   end
   // A toggling decision, used for mid-scale input and while held in reset.
   always @(posedge sample_in) begin
      alt_reg <= ~alt_reg;
   end
   // Overload decisions flip with the chopping polarity, as the real loop does.
   assign bit_out = (mode_in == 2'h2 || mod_reset_in) ? alt_reg : ((mode_in == 2'h0) ^ polarity_in);
endmodule

// [dv/incremental_adc_sequencer_asserts.sv]
// Timing checks on the sequencer's ports.
// Assumes one clock domain and the shared header on the include path.
`timescale 1ns/1ps
`include "incremental_adc_regs.vh"
module adc_seq_checker (
   input wire                    mclk_in,
   input wire                    reset_in,
   input wire                    conversion_trigger_in,
   input wire                    alt_conversion_trigger_in,
   input wire [`BG_MODE_W-1:0]   bandgap_mode_in,
   input wire [`RESULT_W-1:0]    conversion_result_out,
   input wire                    result_valid_out,
   input wire                    busy_out,
   input wire                    offset_polarity_out,
   input wire                    bandgap_state_out,
   input wire                    modulator_reset_out,
   input wire                    os_sample_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   wire trig = conversion_trigger_in | alt_conversion_trigger_in;
   // Starts, and starts with a forced bandgap state.
   sequence start_s; trig; endsequence
   sequence low_s; trig && bandgap_mode_in == `BG_FORCE_LOW; endsequence
   sequence high_s; trig && bandgap_mode_in == `BG_FORCE_HIGH; endsequence
   start_busy_a: assert property (start_s |=> busy_out && !modulator_reset_out) else $error("no start");
   start_polarity_a: assert property (start_s |=> !offset_polarity_out) else $error("bad polarity");
   force_low_a: assert property (low_s |=> (!bandgap_state_out) [*2]) else $error("bandgap not low");
   force_high_a: assert property (high_s |=> bandgap_state_out [*2]) else $error("bandgap not high");
   valid_pulse_a: assert property (result_valid_out |=> !result_valid_out) else $error("valid too long");
   valid_ends_busy_a: assert property (result_valid_out |-> !busy_out && $past(busy_out)) else $error("busy");
   result_hold_a: assert property (!result_valid_out |-> $stable(conversion_result_out)) else $error("drift");
   idle_reset_a: assert property (!busy_out |-> modulator_reset_out) else $error("modulator free");
   sample_pulse_a: assert property (os_sample_out |=> !os_sample_out) else $error("sample too long");
   idle_quiet_a: assert property (os_sample_out |-> busy_out || result_valid_out) else $error("idle sample");
endmodule
bind incremental_adc_sequencer adc_seq_checker chk (.mclk_in(mclk_in), .reset_in(reset_in),
   .conversion_trigger_in(conversion_trigger_in), .alt_conversion_trigger_in(alt_conversion_trigger_in),
   .bandgap_mode_in(bandgap_mode_in), .conversion_result_out(conversion_result_out),
   .result_valid_out(result_valid_out), .busy_out(busy_out), .offset_polarity_out(offset_polarity_out),
   .bandgap_state_out(bandgap_state_out), .modulator_reset_out(modulator_reset_out),
   .os_sample_out(os_sample_out));

// [dv/incremental_adc_sequencer_tb.sv]
// Self-checking bench for the incremental converter sequencer.
// Assumes the modulator model and the shared header are compiled alongside.
`timescale 1ns/1ps
`include "incremental_adc_regs.vh"
module incremental_adc_sequencer_tb;
   reg         mclk_in, reset_in, trig_a, trig_b;
   reg [1:0]   sel, nc, bg, mode, sh;
   reg [2:0]   oc;
   reg [15:0]  m;
   reg         pol_d, bg_d;
   wire        osc, mbit, valid, busy, pol, bgs, mrst, smp;
   wire [15:0] res;
   integer     fail_count, checks_done, cyc, n_smp, n_pol, n_bg, gap, last_gap, i;
   incremental_adc_sequencer dut (.mclk_in(mclk_in), .reset_in(reset_in), .conversion_trigger_in(trig_a),
      .alt_conversion_trigger_in(trig_b), .oversample_clock_select_in(sel), .oversample_ratio_code_in(oc),
      .elem_conversion_count_code_in(nc), .bandgap_mode_in(bg), .osc_4mhz_in(osc), .modulator_bit_in(mbit),
      .conversion_result_out(res), .result_valid_out(valid), .busy_out(busy), .offset_polarity_out(pol),
      .bandgap_state_out(bgs), .modulator_reset_out(mrst), .os_sample_out(smp));
   adc_modulator_model pm (.sample_in(smp), .polarity_in(pol), .mod_reset_in(mrst), .mode_in(mode),
      .osc_out(osc), .bit_out(mbit));
   // 50 MHz clock.
   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   // Counts pulses and toggles since the last start, skipping the two edges it takes to restart.
   always @(posedge mclk_in) begin
      cyc = cyc + 1;
      gap = gap + 1;
      if (smp === 1'b1) begin
         last_gap = gap;
         gap = 0;
      end
      if (sh != 2'h0) begin
         n_smp = 0; n_pol = 0; n_bg = 0;
      end else begin
         n_smp = n_smp + (smp === 1'b1);
         n_pol = n_pol + (pol !== pol_d);
         n_bg = n_bg + (bgs !== bg_d);
      end
      sh = {sh[0], trig_a | trig_b};
      pol_d = pol;
      bg_d = bgs;
      if (cyc > 100000) begin
         fail_count = fail_count + 1;
         results;
      end
   end
   task results;
      begin
         $display("checks %0d mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [8*24-1:0] name, input [15:0] exp, input [15:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task chk_cnt(input [8*24-1:0] name, input integer exp, input integer got, input integer tol);
      begin
         checks_done = checks_done + 1;
         if (^got === 1'bx || got < exp - tol || got > exp + tol) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s expected %0d seen %0d", name, exp, got);
         end
      end
   endtask
   // One-cycle start on either trigger input.
   task pulse(input integer kind);
      begin
         trig_a = (kind == 0);
         trig_b = (kind != 0);
         @(negedge mclk_in);
         trig_a = 1'b0;
         trig_b = 1'b0;
      end
   endtask
   // Starts a sequence, optionally restarts it after pre cycles, and waits for the result.
   task run(input integer kind, input integer pre);
      integer w;
      begin
         @(negedge mclk_in);
         if (pre > 0) begin
            pulse(kind);
            repeat (pre) @(negedge mclk_in);
         end
         pulse(kind);
         w = 0;
         while (valid !== 1'b1 && w < 30000) begin
            @(negedge mclk_in);
            w = w + 1;
         end
         // A sequence that never finishes is a mismatch and ends the run.
         if (valid !== 1'b1) begin
            fail_count = fail_count + 1;
            results;
         end
         repeat (20) @(negedge mclk_in);
      end
   endtask
   // Non-significant low bits of the result for the given codes.
   function [15:0] low_mask(input [2:0] o, input [1:0] c);
      integer n;
      begin
         n = 2 * (3 + o) + c;
         low_mask = (n >= 16) ? 16'h0000 : ((16'h0001 << (16 - n)) - 16'h0001);
      end
   endfunction
   // Reset, then random overload and mid-scale runs, clock rates and a restart.
   initial begin
      reset_in = 1'b1; trig_a = 1'b0; trig_b = 1'b0; sel = 2'h3; oc = 3'h0; nc = 2'h0; bg = 2'h0; mode = 2'h0;
      fail_count = 0; checks_done = 0; cyc = 0; n_smp = 0; n_pol = 0; n_bg = 0; gap = 0; last_gap = 0; sh = 2'h0;
      i = $urandom(64938);
      repeat (2) @(negedge mclk_in);
      reset_in = 1'b0;
      chk("idle result", 16'h0000, res);
      for (i = 0; i < 8; i = i + 1) begin
         nc = i[1:0];
         oc = (i == 0) ? 3'h0 : ($urandom % 2);
         bg = (i < 4) ? i[1:0] : $urandom % 4;
         mode = i % 3;
         run(i % 2, 0);
         m = low_mask(oc, nc);
         chk_cnt("samples", (1 << nc) * ((8 << oc) + 1) + 1, n_smp, 0);
         chk_cnt("polarity toggles", 1 << nc, n_pol, 0);
         chk_cnt("bandgap toggles", (bg == 2) ? (1 << nc) : (bg == 3) ? (1 << nc) / 2 : 0, n_bg, 0);
         if (mode == 2'h2) chk("forced bits", m ^ (m >> 1), res & m);
         else chk("result", ((mode == 2'h0) ? (16'h7FFF & ~m) : 16'h8000) | (m ^ (m >> 1)), res);
      end
      mode = 2'h0; oc = 3'h0; nc = 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
         sel = i[1:0];
         run(0, 0);
         chk_cnt("tick spacing", 800 >> i, last_gap, 2);
      end
      sel = 2'h3;
      // Full resolution: no right shift of the sum and no forced low bits.
      oc = 3'h5;
      run(1, 250);
      chk_cnt("samples after restart", (8 << oc) + 2, n_smp, 0);
      chk("full resolution", 16'h7FFF, res);
      results;
   end
endmodule
